//--- dsp_defines.svh
// register map, field positions and timing constants for the serial ports
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH
`define DSP_ADDR_MODE 5'h10
`define DSP_REG_DATA 3'h0
`define DSP_REG_DIVH 3'h1
`define DSP_REG_FCTL 3'h2
`define DSP_REG_LCTL 3'h3
`define DSP_REG_MCTL 3'h4
`define DSP_REG_LSTAT 3'h5
`define DSP_REG_MSTAT 3'h6
`define DSP_REG_SCR 3'h7
`define DSP_LCTL_RESET 8'h03
`define DSP_DIV_RESET 16'h0001
`define DSP_LCTL_BRK 6
`define DSP_LCTL_DLAB 7
`define DSP_MCTL_DTR 0
`define DSP_MCTL_RTS 1
`define DSP_MCTL_LOOP 4
`define DSP_MST_DCD 3
`define DSP_MST_CTS 4
`define DSP_MST_DSR 5
`define DSP_MST_RI 6
`define DSP_FCTL_RXCLR 1
`define DSP_FCTL_TXCLR 2
`define DSP_FCTL_TRIG 6
`define DSP_LST_DR 0
`define DSP_LST_OE 1
`define DSP_LST_PE 2
`define DSP_LST_FE 3
`define DSP_LST_BI 4
`define DSP_LST_THRE 5
`define DSP_LST_TEMT 6
`define DSP_MODE_FIFO0 4
`define DSP_DEPTH 5'h10
`define DSP_DEPTH_STD 5'h01
`define DSP_TRIG_1 5'h01
`define DSP_TRIG_4 5'h04
`define DSP_TRIG_8 5'h08
`define DSP_TRIG_14 5'h0E
`define DSP_NUM_REF 3
`define DSP_CLK_RATE 19'h30D40
`define DSP_REF0_RATE 19'h0481E
`define DSP_REF1_RATE 19'h07800
`define DSP_REF2_RATE 19'h13880
`define DSP_OVS_LAST 4'hF
`define DSP_OVS_HALF 4'h7
`define DSP_WLEN_BASE 3'h4
`define DSP_WLAST 3'h7
`endif

//--- dsp_pkg.sv
// shared types and parity helper for the serial ports
package dsp_pkg;
  // line format as set by the line control register
  typedef struct packed {
    logic [1:0] wlen;
    logic stop2;
    logic par_en;
    logic par_even;
  } dsp_line_cfg_t;
  // one received character with its error flags
  typedef struct packed {
    logic brk;
    logic ferr;
    logic perr;
    logic [7:0] data;
  } dsp_rx_word_t;
  // serial framing states, shared by both directions
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
  } dsp_ser_state_t;
  // parity bit for a character whose unused high bits are zero
  function automatic logic dsp_par(input logic [7:0] d, input logic even);
    dsp_par = even ? ^d : ~^d;
  endfunction : dsp_par
endpackage : dsp_pkg

//--- dsp_tx.sv
// serial transmitter: adds start, parity and stop bits
`timescale 1ns/1ps
`include "dsp_defines.svh"
module dsp_tx (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick16_in,
  input wire dsp_pkg::dsp_line_cfg_t cfg_in,
  input wire logic have_in,
  input wire logic [7:0] data_in,
  output logic take_out,
  output logic busy_out,
  output logic bit_out
);
  dsp_pkg::dsp_ser_state_t state; // framing state
  logic [7:0] shift; // data bits still to go, lsb first
  logic [3:0] sub; // oversample count within a bit
  logic [2:0] nbit; // index of the bit on the line
  logic par; // parity bit for this character
  logic stop_left; // second stop bit pending
  logic [2:0] last; // index of the last data bit
  logic [7:0] masked; // character without unused high bits
  assign last = {1'b0, cfg_in.wlen} + `DSP_WLEN_BASE;
  assign masked = data_in & (8'hFF >> (`DSP_WLAST - last));
  assign busy_out = state != dsp_pkg::ST_IDLE;
  // framing engine, one bit every sixteen baud ticks
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= dsp_pkg::ST_IDLE;
      bit_out <= 1'b1;
      take_out <= 1'b0;
      shift <= 8'h00;
      sub <= 4'h0;
      nbit <= 3'h0;
      par <= 1'b0;
      stop_left <= 1'b0;
    end else begin
      take_out <= 1'b0;
      case (state)
        dsp_pkg::ST_IDLE: begin
          if (have_in && tick16_in) begin
            shift <= masked;
            par <= dsp_pkg::dsp_par(masked, cfg_in.par_even);
            take_out <= 1'b1;
            bit_out <= 1'b0;
            sub <= 4'h0;
            state <= dsp_pkg::ST_START;
          end
        end
        default: begin
          if (tick16_in) begin
            sub <= sub + 4'h1;
            if (sub == `DSP_OVS_LAST) begin
              case (state)
                dsp_pkg::ST_START: begin
                  bit_out <= shift[0];
                  shift <= shift >> 1;
                  nbit <= 3'h0;
                  state <= dsp_pkg::ST_DATA;
                end
                dsp_pkg::ST_DATA: begin
                  if (nbit != last) begin
                    bit_out <= shift[0];
                    shift <= shift >> 1;
                    nbit <= nbit + 3'h1;
                  end else if (cfg_in.par_en) begin
                    bit_out <= par;
                    state <= dsp_pkg::ST_PAR;
                  end else begin
                    bit_out <= 1'b1;
                    stop_left <= cfg_in.stop2;
                    state <= dsp_pkg::ST_STOP;
                  end
                end
                dsp_pkg::ST_PAR: begin
                  bit_out <= 1'b1;
                  stop_left <= cfg_in.stop2;
                  state <= dsp_pkg::ST_STOP;
                end
                default: begin
                  if (stop_left) stop_left <= 1'b0;
                  else state <= dsp_pkg::ST_IDLE;
                end
              endcase
            end
          end
        end
      endcase
    end
  end
endmodule : dsp_tx

//--- dsp_rx.sv
// serial receiver: strips start, parity and stop bits
`timescale 1ns/1ps
`include "dsp_defines.svh"
module dsp_rx (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick16_in,
  input wire dsp_pkg::dsp_line_cfg_t cfg_in,
  input wire logic line_in,
  output logic valid_out,
  output dsp_pkg::dsp_rx_word_t word_out
);
  dsp_pkg::dsp_ser_state_t state; // framing state
  logic [7:0] shift; // bits arrive at the top, move down
  logic [3:0] sub; // oversample count
  logic [2:0] nbit; // data bit index
  logic psample; // parity bit as received
  logic [2:0] last; // index of the last data bit
  logic [7:0] aligned; // character moved down to bit 0
  assign last = {1'b0, cfg_in.wlen} + `DSP_WLEN_BASE;
  assign aligned = shift >> (`DSP_WLAST - last);
  // sample mid bit, every sixteen ticks after the start centre
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= dsp_pkg::ST_IDLE;
      valid_out <= 1'b0;
      word_out <= '0;
      shift <= 8'h00;
      sub <= 4'h0;
      nbit <= 3'h0;
      psample <= 1'b0;
    end else begin
      valid_out <= 1'b0;
      case (state)
        dsp_pkg::ST_IDLE: begin
          if (!line_in) begin
            sub <= 4'h0;
            state <= dsp_pkg::ST_START;
          end
        end
        dsp_pkg::ST_START: begin
          if (tick16_in) begin
            sub <= sub + 4'h1;
            if (sub == `DSP_OVS_HALF) begin
              // a glitch shorter than half a bit is no start
              sub <= 4'h0;
              nbit <= 3'h0;
              shift <= 8'h00;
              state <= line_in ? dsp_pkg::ST_IDLE : dsp_pkg::ST_DATA;
            end
          end
        end
        default: begin
          if (tick16_in) begin
            sub <= sub + 4'h1;
            if (sub == `DSP_OVS_LAST) begin
              case (state)
                dsp_pkg::ST_DATA: begin
                  shift <= {line_in, shift[7:1]};
                  nbit <= nbit + 3'h1;
                  if (nbit == last) begin
                    state <= cfg_in.par_en ? dsp_pkg::ST_PAR
                                           : dsp_pkg::ST_STOP;
                  end
                end
                dsp_pkg::ST_PAR: begin
                  psample <= line_in;
                  state <= dsp_pkg::ST_STOP;
                end
                default: begin
                  valid_out <= 1'b1;
                  word_out.data <= aligned;
                  word_out.perr <= cfg_in.par_en &&
                    (psample != dsp_pkg::dsp_par(aligned, cfg_in.par_even));
                  word_out.ferr <= !line_in;
                  word_out.brk <= (aligned == 8'h00) && !line_in &&
                    !(cfg_in.par_en && psample);
                  state <= dsp_pkg::ST_IDLE;
                end
              endcase
            end
          end
        end
      endcase
    end
  end
endmodule : dsp_rx

//--- dsp_top.sv
// dual serial port: register file, queues, reference and baud clocks
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "dsp_defines.svh"
// Operation
// - two ports, each fifo or unbuffered
// - sixteen byte transmit and receive queues
// - receive threshold one, four, eight, fourteen
// - three reference clocks from one input
// - per port divisor, selectable reference clock
// - add framing on send, strip on receive
// - send break, detect incoming break
// - loopback feeds own output to receiver
// - serial output marks after reset
// - data set ready shows status bit five
// - ring indicator shows status bit six
// - carrier detect shows status bit three
// - clear to send shows status bit four
// - terminal ready follows control bit zero
// - request to send follows control bit one
// - bit zero is lsb, sent first
module dsp_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [1:0] serial_rx_in,
  output logic [1:0] serial_tx_out,
  input wire logic [1:0] cts_in,
  input wire logic [1:0] dsr_in,
  input wire logic [1:0] ri_in,
  input wire logic [1:0] carrier_detect_in,
  output logic [1:0] dtr_out,
  output logic [1:0] rts_out
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // queue limit: a full queue in fifo mode, a single holding register else
  function automatic logic [4:0] depth_lim(input logic fifo);
    depth_lim = fifo ? `DSP_DEPTH : `DSP_DEPTH_STD;
  endfunction : depth_lim

  // next queue slot, wraps at sixteen
  function automatic logic [3:0] ptr_next(input logic [3:0] p);
    ptr_next = p + 4'h1;
  endfunction : ptr_next

  ////////////////////////////////////////////////////////////////////////
  // reference clocks

  // rates in 100 Hz units; the 48 MHz source is modelled by
  // fractional accumulators on the 20 MHz system clock, so each
  // reference is an average-rate tick, not a clean square wave
  localparam logic [18:0] REF_RATE [`DSP_NUM_REF] = '{
    `DSP_REF0_RATE, `DSP_REF1_RATE, `DSP_REF2_RATE};
  logic [18:0] ref_acc [`DSP_NUM_REF]; // phase per reference
  logic [`DSP_NUM_REF-1:0] ref_tick; // one-cycle reference ticks
  logic [7:0] mode; // port mode and clock select

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < `DSP_NUM_REF; i++) begin
      if (!rst_n_in) begin
        ref_acc[i] <= '0;
        ref_tick[i] <= 1'b0;
      end else if (ref_acc[i] + REF_RATE[i] >= `DSP_CLK_RATE) begin
        ref_acc[i] <= ref_acc[i] + REF_RATE[i] - `DSP_CLK_RATE;
        ref_tick[i] <= 1'b1;
      end else begin
        ref_acc[i] <= ref_acc[i] + REF_RATE[i];
        ref_tick[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode register, shared by both ports

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) mode <= 8'h00;
    else if (wr_in && addr_in == `DSP_ADDR_MODE) mode <= wdata_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-port logic

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic sel; // bus targets this port
    logic fifo_mode; // buffered operation
    logic [1:0] ref_sel; // reference clock choice
    logic [7:0] lctl; // line control
    logic [7:0] mctl; // modem control
    logic [7:0] scratch; // software scratch byte
    logic [15:0] div; // baud divisor
    logic [1:0] trig; // receive threshold code
    logic dlab; // divisor access
    logic loop; // loopback active
    logic [15:0] baud_cnt; // reference ticks within a baud/16
    logic tick16; // sixteen per bit
    logic [7:0] tq [16]; // transmit queue
    logic [3:0] tq_wp, tq_rp; // transmit pointers
    logic [4:0] tq_cnt; // transmit fill
    dsp_pkg::dsp_rx_word_t rq [16]; // receive queue
    logic [3:0] rq_wp, rq_rp; // receive pointers
    logic [4:0] rq_cnt; // receive fill
    logic oe, pe, fe, bi; // sticky line errors
    logic [3:0] m_s1, m_s2; // modem input synchroniser
    logic rx_s1, rx_s2; // serial input synchroniser
    logic tx_bit, tx_take, tx_busy; // transmitter side
    logic rx_valid; // character arrived
    dsp_pkg::dsp_rx_word_t rx_word; // arrived character
    logic tx_line; // transmitted stream incl. break
    logic rx_line; // receiver input after loop mux
    logic wr_data, rd_data, rd_lstat, tx_push, rx_pop, rx_push;
    logic [7:0] msr, lsr, prd; // status views and read mux
    dsp_pkg::dsp_line_cfg_t cfg; // line format

    assign sel = !addr_in[4] && addr_in[3] == p[0];
    assign fifo_mode = mode[`DSP_MODE_FIFO0 + p];
    assign ref_sel = mode[2*p +: 2];
    assign dlab = lctl[`DSP_LCTL_DLAB];
    assign loop = mctl[`DSP_MCTL_LOOP];
    assign cfg = '{wlen: lctl[1:0], stop2: lctl[2], par_en: lctl[3],
                   par_even: lctl[4]};
    assign wr_data = wr_in && sel && addr_in[2:0] == `DSP_REG_DATA;
    assign rd_data = rd_in && sel && addr_in[2:0] == `DSP_REG_DATA;
    assign rd_lstat = rd_in && sel && addr_in[2:0] == `DSP_REG_LSTAT;
    // writes to a full queue are dropped
    assign tx_push = wr_data && !dlab && tq_cnt < depth_lim(fifo_mode);
    assign rx_pop = rd_data && !dlab && rq_cnt != 5'h00;
    assign rx_push = rx_valid && rq_cnt < depth_lim(fifo_mode);

    // control registers written by the host
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        lctl <= `DSP_LCTL_RESET;
        mctl <= 8'h00;
        scratch <= 8'h00;
        div <= `DSP_DIV_RESET;
        trig <= 2'b00;
      end else if (wr_in && sel) begin
        if (addr_in[2:0] == `DSP_REG_DATA) begin
          if (dlab) div[7:0] <= wdata_in;
        end else if (addr_in[2:0] == `DSP_REG_DIVH) begin
          if (dlab) div[15:8] <= wdata_in;
        end else if (addr_in[2:0] == `DSP_REG_FCTL) begin
          trig <= wdata_in[`DSP_FCTL_TRIG +: 2];
        end else if (addr_in[2:0] == `DSP_REG_LCTL) begin
          lctl <= wdata_in;
        end else if (addr_in[2:0] == `DSP_REG_MCTL) begin
          mctl <= wdata_in;
        end else if (addr_in[2:0] == `DSP_REG_SCR) begin
          scratch <= wdata_in;
        end
      end
    end

    assign dtr_out[p] = mctl[`DSP_MCTL_DTR];
    assign rts_out[p] = mctl[`DSP_MCTL_RTS];

    // baud divider on chosen reference; divisor zero halts it
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        baud_cnt <= 16'h0000;
        tick16 <= 1'b0;
      end else begin
        tick16 <= 1'b0;
        if (ref_tick[ref_sel == 2'b11 ? 2'b00 : ref_sel] &&
            div != 16'h0000) begin
          if (baud_cnt >= div - 16'h0001) begin
            baud_cnt <= 16'h0000;
            tick16 <= 1'b1;
          end else begin
            baud_cnt <= baud_cnt + 16'h0001;
          end
        end
      end
    end

    // transmit queue; clear flushes unsent bytes only
    always_ff @(posedge clk_in) begin
      if (!rst_n_in || (wr_in && sel && addr_in[2:0] == `DSP_REG_FCTL &&
                        wdata_in[`DSP_FCTL_TXCLR])) begin
        tq_wp <= 4'h0;
        tq_rp <= 4'h0;
        tq_cnt <= 5'h00;
      end else begin
        if (tx_push) begin
          tq[tq_wp] <= wdata_in;
          tq_wp <= ptr_next(tq_wp);
        end
        if (tx_take) tq_rp <= ptr_next(tq_rp);
        tq_cnt <= tq_cnt + {4'h0, tx_push} - {4'h0, tx_take};
      end
    end

    // receive queue; read of the data register pops the head
    always_ff @(posedge clk_in) begin
      if (!rst_n_in || (wr_in && sel && addr_in[2:0] == `DSP_REG_FCTL &&
                        wdata_in[`DSP_FCTL_RXCLR])) begin
        rq_wp <= 4'h0;
        rq_rp <= 4'h0;
        rq_cnt <= 5'h00;
      end else begin
        if (rx_push) begin
          rq[rq_wp] <= rx_word;
          rq_wp <= ptr_next(rq_wp);
        end
        if (rx_pop) rq_rp <= ptr_next(rq_rp);
        rq_cnt <= rq_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
      end
    end

    // sticky errors: a new event in the clearing read still sets
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        oe <= 1'b0;
        pe <= 1'b0;
        fe <= 1'b0;
        bi <= 1'b0;
      end else begin
        oe <= (oe && !rd_lstat) || (rx_valid && !rx_push);
        pe <= (pe && !rd_lstat) || (rx_push && rx_word.perr);
        fe <= (fe && !rd_lstat) || (rx_push && rx_word.ferr);
        bi <= (bi && !rd_lstat) || (rx_push && rx_word.brk);
      end
    end

    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        m_s1 <= 4'h0;
        m_s2 <= 4'h0;
        rx_s1 <= 1'b1;
        rx_s2 <= 1'b1;
      end else begin
        m_s1 <= {ri_in[p], dsr_in[p], cts_in[p], carrier_detect_in[p]};
        m_s2 <= m_s1;
        rx_s1 <= serial_rx_in[p];
        rx_s2 <= rx_s1;
      end
    end

    // modem status view
    always_comb begin
      msr = 8'h00;
      msr[`DSP_MST_DCD] = m_s2[0];
      msr[`DSP_MST_CTS] = m_s2[1];
      msr[`DSP_MST_DSR] = m_s2[2];
      msr[`DSP_MST_RI] = m_s2[3];
    end

    // line status view
    always_comb begin
      lsr = 8'h00;
      lsr[`DSP_LST_DR] = rq_cnt != 5'h00;
      lsr[`DSP_LST_OE] = oe;
      lsr[`DSP_LST_PE] = pe;
      lsr[`DSP_LST_FE] = fe;
      lsr[`DSP_LST_BI] = bi;
      lsr[`DSP_LST_THRE] = tq_cnt == 5'h00;
      lsr[`DSP_LST_TEMT] = tq_cnt == 5'h00 && !tx_busy;
    end

    // threshold reached, shown in bit 0 of the fifo status read
    function automatic logic [4:0] trig_lvl(input logic [1:0] t);
      case (t)
        2'b00: trig_lvl = `DSP_TRIG_1;
        2'b01: trig_lvl = `DSP_TRIG_4;
        2'b10: trig_lvl = `DSP_TRIG_8;
        default: trig_lvl = `DSP_TRIG_14;
      endcase
    endfunction : trig_lvl

    // register read mux for this port
    always_comb begin
      prd = 8'h00;
      if (addr_in[2:0] == `DSP_REG_DATA) begin
        prd = dlab ? div[7:0] : rq[rq_rp].data;
      end else if (addr_in[2:0] == `DSP_REG_DIVH) begin
        prd = dlab ? div[15:8] : 8'h00;
      end else if (addr_in[2:0] == `DSP_REG_FCTL) begin
        prd = {fifo_mode, fifo_mode, 5'h00,
               fifo_mode && rq_cnt >= trig_lvl(trig)};
      end else if (addr_in[2:0] == `DSP_REG_LCTL) begin
        prd = lctl;
      end else if (addr_in[2:0] == `DSP_REG_MCTL) begin
        prd = mctl;
      end else if (addr_in[2:0] == `DSP_REG_LSTAT) begin
        prd = lsr;
      end else if (addr_in[2:0] == `DSP_REG_MSTAT) begin
        prd = msr;
      end else begin
        prd = scratch;
      end
    end

    dsp_tx u_tx (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .tick16_in(tick16),
      .cfg_in(cfg),
      .have_in(tq_cnt != 5'h00),
      .data_in(tq[tq_rp]),
      .take_out(tx_take),
      .busy_out(tx_busy),
      .bit_out(tx_bit)
    );

    assign tx_line = tx_bit && !lctl[`DSP_LCTL_BRK];
    assign rx_line = loop ? tx_line : rx_s2;

    dsp_rx u_rx (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .tick16_in(tick16),
      .cfg_in(cfg),
      .line_in(rx_line),
      .valid_out(rx_valid),
      .word_out(rx_word)
    );

    always_ff @(posedge clk_in) begin
      if (!rst_n_in) serial_tx_out[p] <= 1'b1;
      else serial_tx_out[p] <= loop || tx_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !rd_in) rdata_out <= 8'h00;
    else if (addr_in == `DSP_ADDR_MODE) rdata_out <= mode;
    else if (addr_in[4]) rdata_out <= 8'h00;
    else if (addr_in[3]) rdata_out <= g_port[1].prd;
    else rdata_out <= g_port[0].prd;
  end

endmodule : dsp_top

//--- dsp_chk.sv
// pin-level assertions for the dual serial port
`timescale 1ns/1ps
module dsp_chk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [1:0] serial_tx_out,
  input wire logic [1:0] cts_in,
  input wire logic [1:0] dsr_in,
  input wire logic [1:0] ri_in,
  input wire logic [1:0] carrier_detect_in,
  input wire logic [1:0] dtr_out,
  input wire logic [1:0] rts_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // port 0 modem status read, or a port modem control write
  wire msr_rd = rd_in && addr_in == 5'h06;
  wire mcr_wr = wr_in && !addr_in[4] && addr_in[2:0] == 3'h4;
  //////////////////////////////////////////////////////////////////////////
  chk_reset_mark:
    assert property ($rose(rst_n_in) |-> serial_tx_out == 2'h3)
    else $error("output not marking after reset");
  chk_dtr_zero:
    assert property (wr_in && addr_in == 5'h04 |=>
      dtr_out[0] == $past(wdata_in[0])) else $error("dtr0 wrong");
  chk_rts_zero:
    assert property (wr_in && addr_in == 5'h04 |=>
      rts_out[0] == $past(wdata_in[1])) else $error("rts0 wrong");
  chk_dtr_one:
    assert property (wr_in && addr_in == 5'h0C |=>
      dtr_out[1] == $past(wdata_in[0])) else $error("dtr1 wrong");
  chk_ctl_hold:
    assert property (!mcr_wr |=> $stable({dtr_out, rts_out}))
    else $error("modem outputs moved");
  chk_dsr_bit:
    assert property (($stable(dsr_in[0]))[*4] ##0 msr_rd |=>
      rdata_out[5] == $past(dsr_in[0])) else $error("dsr bit wrong");
  chk_ri_bit:
    assert property (($stable(ri_in[0]))[*4] ##0 msr_rd |=>
      rdata_out[6] == $past(ri_in[0])) else $error("ri bit wrong");
  chk_cd_bit:
    assert property (($stable(carrier_detect_in[0]))[*4] ##0 msr_rd |=>
      rdata_out[3] == $past(carrier_detect_in[0])) else $error("cd wrong");
  chk_cts_bit:
    assert property (($stable(cts_in[0]))[*4] ##0 msr_rd |=>
      rdata_out[4] == $past(cts_in[0])) else $error("cts bit wrong");
endmodule : dsp_chk
bind dsp_top dsp_chk u_dsp_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .serial_tx_out(serial_tx_out), .cts_in(cts_in),
  .dsr_in(dsr_in), .ri_in(ri_in), .carrier_detect_in(carrier_detect_in),
  .dtr_out(dtr_out), .rts_out(rts_out));

//--- dsp_modem.sv
// far side model: crossed serial cable and modem lines
`timescale 1ns/1ps
module dsp_modem (
  input wire logic clk_in,
  input wire logic [1:0] tx_in,
  input wire logic [7:0] lines_in,
  input wire logic jam_in,
  output logic [1:0] rx_out,
  output logic [1:0] cts_out,
  output logic [1:0] dsr_out,
  output logic [1:0] ri_out,
  output logic [1:0] cd_out
);
  // rate kept low: bench runs 500k
  always_ff @(posedge clk_in) begin
    // jam holds port 0 input low, a break from far side
    rx_out <= {tx_in[0], tx_in[1] & ~jam_in};
    {ri_out, dsr_out, cts_out, cd_out} <= lines_in;
  end
endmodule : dsp_modem

//--- dsp_top_tb_top.sv
// self-checking bench for the dual serial port
`timescale 1ns/1ps
module dsp_top_tb_top;
  logic clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic jam = 1'b0;
  logic [4:0] addr_in = 5'h00;
  logic [7:0] wdata_in = 8'h00, lines = 8'h00, rdata_out, got, d;
  logic [1:0] rx, tx, cts, dsr, ri, cd, dtr, rts;
  logic [9:0] frm;
  logic [7:0] q [5]; // bytes queued in the buffered burst
  logic [31:0] seed = 32'h00017084;
  logic [31:0] r;
  int errors = 0, cmp_count = 0, k;
  dsp_top u_dsp_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .serial_rx_in(rx), .serial_tx_out(tx), .cts_in(cts), .dsr_in(dsr),
    .ri_in(ri), .carrier_detect_in(cd), .dtr_out(dtr), .rts_out(rts));
  dsp_modem u_dsp_modem (.clk_in(clk_in), .tx_in(tx), .lines_in(lines),
    .jam_in(jam), .rx_out(rx), .cts_out(cts), .dsr_out(dsr), .ri_out(ri),
    .cd_out(cd));
  initial forever #25 clk_in = ~clk_in;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // status byte: cd bit 3, cts 4, dsr 5, ri 6
  function automatic logic [9:0] msr(input logic [7:0] l, input int p);
    return {3'h0, l[6+p], l[4+p], l[2+p], l[p], 3'h0};
  endfunction : msr
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 got = rdata_out;
  endtask : rd
  // mid-bit samples of one port 0 frame, 40 clocks a bit
  task automatic grab();
    for (k = 0; k < 2000 && tx[0]; k++) @(posedge clk_in);
    repeat (20) @(posedge clk_in);
    chk(tx[0], 1'b0);
    for (k = 0; k < 10; k++) begin
      repeat (40) @(posedge clk_in);
      frm[k] = tx[0];
    end
  endtask : grab
  task automatic test_done();
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk(tx, 2'h3);
    rd(5'h03);
    chk(got, 8'h03);
    // random modem lines and control bits on both ports
    repeat (4) begin
      r = rnd();
      lines <= r[7:0];
      wr(5'h04, r[15:8] & 8'hEF);
      wr(5'h0C, r[23:16] & 8'hEF);
      repeat (6) @(posedge clk_in);
      chk({dtr, rts}, {r[16], r[8], r[17], r[9]});
      rd(5'h06);
      chk(got & 8'h78, msr(r[7:0], 0));
      rd(5'h0E);
      chk(got & 8'h78, msr(r[7:0], 1));
    end
    wr(5'h04, 8'h00);
    $display("modem test done");
    // both ports on the 8 MHz reference, divisor 1: 500k
    wr(5'h10, 8'h0A);
    for (int n = 0; n < 6; n++) begin
      r = rnd();
      d = n == 0 ? 8'h00 : n == 1 ? 8'hFF : r[7:0];
      wr(5'h03, n[0] ? 8'h1B : 8'h03);
      wr(5'h0B, n[0] ? 8'h1B : 8'h03);
      wr(5'h00, d);
      grab();
      chk(frm, n[0] ? {1'b1, ^d, d} : {2'h3, d});
      repeat (40) @(posedge clk_in);
      rd(5'h0D);
      chk(got & 8'h1F, 8'h01);
      rd(5'h08);
      chk(got, d);
    end
    $display("frame test done");
    // both ports buffered, five bytes queued, threshold four
    wr(5'h10, 8'h3A);
    wr(5'h0A, 8'h40);
    for (int n = 0; n < 5; n++) begin
      r = rnd();
      q[n] = r[7:0];
      wr(5'h00, q[n]);
    end
    repeat (2400) @(posedge clk_in);
    rd(5'h0A);
    chk(got, 8'hC1);
    for (int n = 0; n < 4; n++) begin
      rd(5'h08);
      chk(got, q[n]);
    end
    rd(5'h0A);
    chk(got, 8'hC0);
    // clearing the receive queue drops the last byte
    wr(5'h0A, 8'h42);
    rd(5'h0D);
    chk(got[0], 1'b0);
    $display("fifo test done");
    // loopback ignores a line held low and keeps the output marking
    jam <= 1'b1;
    wr(5'h04, 8'h10);
    wr(5'h00, 8'hA5);
    repeat (500) begin
      @(posedge clk_in);
      chk(tx[0], 1'b1);
    end
    rd(5'h00);
    chk(got, 8'hA5);
    wr(5'h04, 8'h00);
    repeat (1000) @(posedge clk_in);
    rd(5'h05);
    chk(got[4], 1'b1);
    jam <= 1'b0;
    $display("loopback test done");
    wr(5'h03, 8'h40);
    repeat (50) @(posedge clk_in);
    chk(tx[0], 1'b0);
    wr(5'h03, 8'h03);
    $display("break test done");
    test_done();
  end
  // watchdog well beyond the expected run of some 7000 clocks
  initial begin
    #1000000;
    errors++;
    test_done();
  end
endmodule : dsp_top_tb_top
